// ### rtl/cpu_powerup_reset_sequence.sv
// Processor-side power-up and reset sequencer.
// Assumes the chipset keeps the power good and reset ordering it owes.
`timescale 1ns/1ns
module cpu_powerup_reset_sequence
(
   input  wire logic                           clock,
   input  wire logic                           rst,
   input  wire logic                           power_good_in,
   input  wire logic                           proc_reset_n,
   input  wire logic                           bridge_reset_n,
   input  wire logic                           bus_connect,
   input  wire logic [pwrseq_pkg::VID_W-1:0]   strapped_voltage_id,
   input  wire logic [pwrseq_pkg::FID_W-1:0]   fuse_freq_id,
   input  wire logic                           pll_locked,
   output logic                                pll_enable,
   output logic                                clock_sel_pll,
   output logic [pwrseq_pkg::VID_W-1:0]        soft_voltage_id,
   output logic                                soft_vid_valid,
   output logic [pwrseq_pkg::FID_W-1:0]        freq_id_code,
   output logic                                freq_id_valid,
   output logic                                core_reset,
   output logic                                proc_ready,
   output logic                                fwd_clock_reset,
   output logic                                sip_start,
   output logic                                connect_seen
);
   typedef struct packed
   {
      pwrseq_pkg::seq_state_t       state;
      logic                         pg_seen;
      logic                         sel_pll;
      logic [pwrseq_pkg::VID_W-1:0] svid;
      logic [pwrseq_pkg::FID_W-1:0] fid;
      logic                         fid_by_rst;
      logic                         rst_s1;
      logic                         rst_s2;
      logic                         conn_seen;
      logic                         conn_prev;
      logic                         sip_go;
      logic                         ready;
      logic                         fwd_rst;
   } seq_t;

   seq_t st_ff;
   seq_t nxt_st;
   logic svid_done;
   logic fid_done_pg;
   logic lock_done;
   logic fid_done_rst;
   logic pg_start;

   // Timers start on the sampled power good itself, not a cycle later;
   // waiting for the sticky copy would push both flags past their limits
   assign pg_start = st_ff.pg_seen || power_good_in;

   // The timers run while their start condition holds
   delay_timer #(.COUNT(pwrseq_pkg::SVID_CYC)) u_svid_tmr
   (
      .clock (clock),
      .rst   (rst),
      .start (pg_start),
      .done  (svid_done)
   );
   delay_timer #(.COUNT(pwrseq_pkg::FID_CYC)) u_fid_tmr
   (
      .clock (clock),
      .rst   (rst),
      .start (pg_start),
      .done  (fid_done_pg)
   );
   // Reset entry alone also makes the code valid, even before power good
   delay_timer #(.COUNT(pwrseq_pkg::FID_CYC)) u_fid_rst_tmr
   (
      .clock (clock),
      .rst   (rst),
      .start (!proc_reset_n),
      .done  (fid_done_rst)
   );
   delay_timer #(.COUNT(pwrseq_pkg::PLL_LOCK_CYC)) u_lock_tmr
   (
      .clock (clock),
      .rst   (rst),
      .start (st_ff.sel_pll),
      .done  (lock_done)
   );

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sip_go = 1'b0;
      // Two stages before the core sees reset release
      nxt_st.rst_s1 = proc_reset_n;
      nxt_st.rst_s2 = st_ff.rst_s1;
      nxt_st.conn_prev = bus_connect;
      // Latched once; a later power good drop is ignored on purpose
      if (power_good_in)
         nxt_st.pg_seen = 1'b1;
      // Clock source moves once and never back
      if (st_ff.pg_seen)
         nxt_st.sel_pll = 1'b1;
      // Straps are copied only after power good
      if (st_ff.pg_seen)
         nxt_st.svid = strapped_voltage_id;
      // Frequency id loads on power good or on reset entry
      if (power_good_in || !proc_reset_n)
         nxt_st.fid = fuse_freq_id;
      // Kept until rst, since the reset timer clears on reset release
      if (fid_done_rst)
         nxt_st.fid_by_rst = 1'b1;
      case (st_ff.state)
         pwrseq_pkg::ST_RING:
         begin
            if (power_good_in)
               nxt_st.state = pwrseq_pkg::ST_LOCK;
         end
         pwrseq_pkg::ST_LOCK:
         begin
            if (pll_locked || lock_done)
               nxt_st.state = pwrseq_pkg::ST_RESET;
         end
         pwrseq_pkg::ST_RESET:
         begin
            nxt_st.ready   = 1'b0;
            nxt_st.fwd_rst = 1'b1;
            // Connect during reset is only bridge reset, not a packet
            if (!st_ff.rst_s2 && bus_connect)
               nxt_st.conn_seen = 1'b1;
            if (st_ff.rst_s2)
               nxt_st.state = pwrseq_pkg::ST_IDLE;
         end
         pwrseq_pkg::ST_IDLE:
         begin
            if (!st_ff.rst_s2)
            begin
               nxt_st.state     = pwrseq_pkg::ST_RESET;
               nxt_st.conn_seen = 1'b0;
            end
            else if (bus_connect && !st_ff.conn_prev)
            begin
               nxt_st.sip_go  = 1'b1;
               nxt_st.fwd_rst = 1'b0;
               nxt_st.ready   = 1'b1;
               nxt_st.state   = pwrseq_pkg::ST_PACKET;
            end
         end
         pwrseq_pkg::ST_PACKET:
         begin
            if (!st_ff.rst_s2)
            begin
               nxt_st.state     = pwrseq_pkg::ST_RESET;
               nxt_st.conn_seen = 1'b0;
            end
         end
         default:
            nxt_st.state = pwrseq_pkg::ST_RING;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_ff        <= '0;
         st_ff.state  <= pwrseq_pkg::ST_RING;
         st_ff.fid    <= pwrseq_pkg::FID_DEFAULT;
         st_ff.fwd_rst <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign pll_enable      = st_ff.pg_seen;
   assign clock_sel_pll   = st_ff.sel_pll;
   assign soft_voltage_id = st_ff.svid;
   assign soft_vid_valid  = svid_done;
   assign freq_id_code    = st_ff.fid;
   // Valid within the limit after power good or after reset entry
   assign freq_id_valid   = fid_done_pg || fid_done_rst
                            || st_ff.fid_by_rst;
   assign core_reset      = !st_ff.rst_s2;
   assign proc_ready      = st_ff.ready;
   assign fwd_clock_reset = st_ff.fwd_rst;
   assign sip_start       = st_ff.sip_go;
   assign connect_seen    = st_ff.conn_seen;
endmodule

// ### rtl/pwrseq_pkg.sv
// Constants for the processor power-up and reset sequencer.
// Assumes one 250 MHz system clock and inputs synchronous to it.
// Contract
// - Before power good, internal logic runs from the ring oscillator.
// - Soft voltage id follows strapped id within 20 ns of power good.
// - On power good, start PLL and move clock grid to PLL.
// - After first power good, never switch clock source again.
// - After reset release, bus connect assertion starts an init packet.
// - Frequency id valid within 100 ns after power good.
// - Frequency id valid within 100 ns after processor reset asserts.
// - Packet exchange uses ready, connect, forward reset, all clock synchronous.
package pwrseq_pkg;
   localparam int CLK_MHZ        = 250;
   localparam int SVID_MAX_NS    = 20;
   localparam int FID_MAX_NS     = 100;
   // Longest times round down
   localparam int SVID_CYC       = SVID_MAX_NS * CLK_MHZ / 1000;
   localparam int FID_CYC        = FID_MAX_NS * CLK_MHZ / 1000;
   localparam int PLL_LOCK_NS    = 400;
   localparam int PLL_LOCK_CYC   = PLL_LOCK_NS * CLK_MHZ / 1000;
   localparam int CNT_W          = 8;
   localparam int FID_W          = 4;
   localparam int VID_W          = 5;
   localparam logic [3:0] FID_DEFAULT = 4'h0;
   typedef enum logic [2:0]
   {
      ST_RING    = 3'b000,
      ST_LOCK    = 3'b001,
      ST_RESET   = 3'b010,
      ST_IDLE    = 3'b011,
      ST_PACKET  = 3'b100
   } seq_state_t;
endpackage

// ### rtl/delay_timer.sv
// Up-counting timer that raises done a fixed count after start.
// Assumes start is a level held while the timed condition lasts.
`timescale 1ns/1ns
module delay_timer
#(
   parameter int COUNT = 1
)
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic start,
   output logic      done
);
   typedef struct packed
   {
      logic [pwrseq_pkg::CNT_W-1:0] cnt;
      logic                         done;
   } tmr_t;
   tmr_t st_ff;
   tmr_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      if (!start)
      begin
         nxt_st.cnt  = '0;
         nxt_st.done = 1'b0;
      end
      else if (!st_ff.done)
      begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
         if (st_ff.cnt == pwrseq_pkg::CNT_W'(COUNT - 1))
            nxt_st.done = 1'b1;
      end
   end
   always_ff @(posedge clock)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   assign done = st_ff.done;
endmodule

// ### tb/pwrseq_assertions.sv
// Port timing checks for the power-up sequencer.
// Assumes a bind to the sequencer top, one clock domain.
`timescale 1ns/1ns
module pwrseq_assertions
(
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       power_good_in,
   input wire logic       proc_reset_n,
   input wire logic       bus_connect,
   input wire logic [3:0] fuse_freq_id,
   input wire logic       pll_enable,
   input wire logic       clock_sel_pll,
   input wire logic       soft_vid_valid,
   input wire logic [3:0] freq_id_code,
   input wire logic       freq_id_valid,
   input wire logic       core_reset,
   input wire logic       sip_start
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_pll_on_pg: assert property ($rose(power_good_in) |=> pll_enable)
      else $error("pll enable late");
   a_ring_first: assert property (!pll_enable |-> !clock_sel_pll)
      else $error("pll clock before power good");
   a_sel_sticky: assert property (clock_sel_pll |=> clock_sel_pll)
      else $error("clock source switched back");
   a_svid_time: assert property (
      $rose(power_good_in) |-> ##[1:5] soft_vid_valid) else $error("svid late");
   a_fid_time: assert property (
      $rose(power_good_in) |-> ##[1:25] freq_id_valid) else $error("fid late");
   a_fid_reset: assert property (
      $fell(proc_reset_n) |-> ##[1:25] freq_id_valid)
      else $error("fid late after reset");
   a_fid_value: assert property (
      freq_id_valid |-> freq_id_code == fuse_freq_id) else $error("fid wrong");
   a_core_hold: assert property (
      !proc_reset_n |-> ##[1:3] core_reset) else $error("core not held");
   a_sip_start: assert property (
      $rose(bus_connect) && proc_reset_n && !core_reset |=> sip_start)
      else $error("packet start missed");
   a_sip_pulse: assert property (sip_start |=> !sip_start)
      else $error("start pulse too long");
endmodule

// ### tb/chipset_model.sv
// Chipset reset logic facing the sequencer, behavioural.
// Assumes the bench calls its tasks; holds are scaled down.
`timescale 1ns/1ns
module chipset_model
(
   input  wire logic clock,
   output logic      power_good_in,
   output logic      proc_reset_n,
   output logic      bridge_reset_n,
   output logic      bus_connect
);
   initial
   begin
      power_good_in = 1'b0;
      proc_reset_n = 1'b1;
      bridge_reset_n = 1'b1;
      bus_connect = 1'b0;
   end
   task automatic power_off();
      power_good_in <= 1'b0;
   endtask
   // Drop breaks monotonic power good on purpose
   task automatic run(input bit cold, input int hold, input bit drop);
      @(posedge clock);
      bridge_reset_n <= 1'b0;
      proc_reset_n <= 1'b0;
      bus_connect <= 1'b1;
      repeat (3) @(posedge clock);
      if (cold)
         power_good_in <= 1'b1;
      repeat (hold) @(posedge clock);
      if (drop)
      begin
         power_good_in <= 1'b0;
         @(posedge clock);
         power_good_in <= 1'b1;
      end
      bridge_reset_n <= 1'b0 ^ 1'b1;
      bus_connect <= 1'b0;
      repeat (2) @(posedge clock);
      proc_reset_n <= 1'b1;
      repeat (8) @(posedge clock);
      bus_connect <= 1'b1;
      repeat (4) @(posedge clock);
   endtask
endmodule

// ### tb/cpu_powerup_reset_sequence_tb.sv
// Self-checking bench for the power-up and reset sequencer.
// Assumes the chipset model drives power good, resets and connect.
`timescale 1ns/1ns
`define CHK(g, e) check(16'(g), 16'(e))
module cpu_powerup_reset_sequence_tb;
   logic        clock, rst, power_good_in, proc_reset_n, bridge_reset_n;
   logic        bus_connect, pll_locked, pll_enable, clock_sel_pll;
   logic        soft_vid_valid, freq_id_valid, core_reset, proc_ready;
   logic        fwd_clock_reset, sip_start, connect_seen;
   logic        fid_prev = 1'b0;
   logic [4:0]  strapped_voltage_id, soft_voltage_id;
   logic [3:0]  fuse_freq_id, freq_id_code;
   logic [15:0] exp_q[$];
   int          seed = 58595;
   int          failures = 0;
   int          tests_run = 0;
   cpu_powerup_reset_sequence u_cpu_powerup_reset_sequence
   (
      .clock, .rst, .power_good_in, .proc_reset_n, .bridge_reset_n,
      .bus_connect, .strapped_voltage_id, .fuse_freq_id, .pll_locked,
      .pll_enable, .clock_sel_pll, .soft_voltage_id, .soft_vid_valid,
      .freq_id_code, .freq_id_valid, .core_reset, .proc_ready,
      .fwd_clock_reset, .sip_start, .connect_seen
   );
   chipset_model u_chipset_model
   (
      .clock, .power_good_in, .proc_reset_n, .bridge_reset_n, .bus_connect
   );
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always #2 clock = ~clock;
   // Level flags are compared once, on their first high sample
   always @(posedge clock)
   begin
      fid_prev <= freq_id_valid;
      if (freq_id_valid === 1'b1 && fid_prev !== 1'b1)
         `CHK({soft_vid_valid, soft_voltage_id, freq_id_code},
              exp_q.pop_front());
      if (sip_start === 1'b1)
         `CHK({proc_ready, fwd_clock_reset, clock_sel_pll}, exp_q.pop_front());
   end
   initial
   begin
      clock = 1'b0;
      rst = 1'b1;
      pll_locked = 1'b0;
      strapped_voltage_id = '0;
      fuse_freq_id = '0;
      for (int i = 0; i < 3; i++)
      begin
         u_chipset_model.power_off();
         rst <= 1'b1;
         pll_locked <= (i != 1);
         strapped_voltage_id <= 5'($random(seed));
         fuse_freq_id <= 4'($random(seed));
         repeat (12) @(posedge clock);
         rst <= 1'b0;
         exp_q.push_back(16'({1'b1, strapped_voltage_id, fuse_freq_id}));
         exp_q.push_back(16'h5);
         u_chipset_model.run(1'b1, 150, i == 2);
         exp_q.push_back(16'h5);
         u_chipset_model.run(1'b0, 40, 1'b0);
         `CHK({freq_id_valid, freq_id_code}, {1'b1, fuse_freq_id});
         `CHK(connect_seen, 1'b1);
         `CHK(exp_q.size(), 0);
         $display("test %0d done", i);
      end
      give_verdict();
   end
   initial
   begin
      repeat (100000) @(posedge clock);
      failures++;
      give_verdict();
   end
endmodule
bind cpu_powerup_reset_sequence pwrseq_assertions u_pwrseq_assertions
(
   .clock, .rst, .power_good_in, .proc_reset_n, .bus_connect, .fuse_freq_id,
   .pll_enable, .clock_sel_pll, .soft_vid_valid, .freq_id_code,
   .freq_id_valid, .core_reset, .sip_start
);
